// [bsl_consts.svh]
// Constants for the boundary-scan line driver: widths, cell positions,
// instruction codes and capture patterns.
// Assumes inclusion by bare name from the design files.
`ifndef BSL_CONSTS_SVH
`define BSL_CONSTS_SVH

`define BSL_BYTE_W 9
`define BSL_IR_W 8
`define BSL_CHAIN_LEN 42

// Chain positions, counted from the serial-out end
`define BSL_POS_A_PIN1 41
`define BSL_POS_A_PIN2 40
`define BSL_POS_A_INT 39
`define BSL_POS_B_PIN1 38
`define BSL_POS_B_PIN2 37
`define BSL_POS_B_INT 36
`define BSL_POS_A_IN0 35
`define BSL_POS_B_IN0 26
`define BSL_POS_A_OUT0 17
`define BSL_POS_B_OUT0 8

// Instruction codes, lsb first
`define BSL_CODE_EXTEST 8'h00
`define BSL_CODE_CLAMP 8'h82
`define BSL_CODE_HIGHZ 8'h03
`define BSL_CODE_BYPASS 8'hff

// Fixed low bits of the instruction capture value
`define BSL_IR_CAP_LOW 2'h1

`endif

// [bsl_pkg.sv]
// Types for the boundary-scan line driver.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package bsl_pkg;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
    TAP_PA_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR,
    TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UPD_IR
  } bsl_tap_type;

endpackage
`default_nettype wire

// [bsl_scan_cell.sv]
// One boundary scan cell: a shift stage and, for controlling cells,
// an update stage.
// Assumes capture, shift and update arrive as one-cycle enables.
`timescale 1ns/1ps
`default_nettype none
module bsl_scan_cell #(
  parameter bit CONTROL = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Step enables
  input wire logic capture_en,
  input wire logic shift_en,
  input wire logic update_en,
  // Data
  input wire logic par_in,
  input wire logic ser_in,
  output logic ser_out,
  output logic upd_out
);

  logic shift_reg;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      shift_reg <= 1'b0;
    end else if (capture_en) begin
      shift_reg <= par_in;
    end else if (shift_en) begin
      shift_reg <= ser_in;
    end
  end

  assign ser_out = shift_reg;

  generate
    if (CONTROL) begin : g_ctl
      logic upd_reg;
      always_ff @(posedge clk) begin
        if (!resetn) begin
          upd_reg <= 1'b0;
        end else if (update_en) begin
          upd_reg <= shift_reg;
        end
      end
      assign upd_out = upd_reg;
    end else begin : g_obs
      // Observe-only: no path back into the system data
      assign upd_out = 1'b0;
    end
  endgenerate

endmodule // bsl_scan_cell
`default_nettype wire

// [bsl_line_driver.sv]
// Dual 9-bit tri-state line driver with boundary-scan test access.
// Assumes every pin input is asynchronous to clk; the test clock is
// sampled by clk, which must run well above twice its rate.
//
// What this block does
// - A outputs follow A inputs if both A enable pins are low, else float.
// - B outputs follow B inputs if both B enable pins are low, else float.
// - Each input pin has an observe-only cell that never affects data.
// - Each output and both internal enables have a controlling cell.
// - The internal A enable drives only A outputs, B only B, high active.
// - The bypass stage is one shift stage that captures zero.
// - The 8-bit instruction register captures a fixed value ending in 01.
// - There is no identification register; the captured value stands in.
// - Codes decode to EXTEST, SAMPLE, CLAMP, HIGH-Z, and all others BYPASS.
// - The chain is 42 cells with the enables at 41 down to 36.
// - Inputs sit at 35..18 and outputs at 17..0, each byte's bit 8 nearest serial out.
// - The four-wire test port follows the standard TAP behaviour.
// - Serial out and scan-driven outputs change on test clock falls.
`timescale 1ns/1ps
`default_nettype none
`include "bsl_consts.svh"
module bsl_line_driver #(
  // Arbitrary capture pattern; its low two bits are replaced by 01
  parameter logic [`BSL_IR_W-1:0] IR_CAPTURE = 8'h55,
  // Arbitrary sample/preload code
  parameter logic [`BSL_IR_W-1:0] CODE_SAMPLE = 8'h55
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // System pins
  input wire logic [`BSL_BYTE_W-1:0] a_side_data_in,
  input wire logic [`BSL_BYTE_W-1:0] b_side_data_in,
  input wire logic a_enable_pin_first_n,
  input wire logic a_enable_pin_second_n,
  input wire logic b_enable_pin_first_n,
  input wire logic b_enable_pin_second_n,
  output logic [`BSL_BYTE_W-1:0] a_side_driven_out,
  output logic a_side_out_en,
  output logic [`BSL_BYTE_W-1:0] b_side_driven_out,
  output logic b_side_out_en,
  // Test access port
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_en
);

  localparam int NB = `BSL_BYTE_W;
  localparam int NS = 2 * NB + 7;
  localparam int NC = `BSL_CHAIN_LEN;

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [NS-1:0] pin_meta_reg;
  logic [NS-1:0] pin_sync_reg;
  logic tck_prev_reg;
  wire [NS-1:0] pin_raw = {tck, tms, tdi, a_enable_pin_first_n,
    a_enable_pin_second_n, b_enable_pin_first_n, b_enable_pin_second_n,
    a_side_data_in, b_side_data_in};

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
      tck_prev_reg <= 1'b0;
    end else begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
      tck_prev_reg <= pin_sync_reg[NS-1];
    end
  end

  wire tck_s = pin_sync_reg[NS-1];
  wire tms_s = pin_sync_reg[NS-2];
  wire tdi_s = pin_sync_reg[NS-3];
  wire a_pin1_s = pin_sync_reg[NS-4];
  wire a_pin2_s = pin_sync_reg[NS-5];
  wire b_pin1_s = pin_sync_reg[NS-6];
  wire b_pin2_s = pin_sync_reg[NS-7];
  wire [NB-1:0] a_in_s = pin_sync_reg[2*NB-1:NB];
  wire [NB-1:0] b_in_s = pin_sync_reg[NB-1:0];
  wire tck_rise = tck_s && !tck_prev_reg;  // Sampling edge
  wire tck_fall = !tck_s && tck_prev_reg;  // Driving edge

  //////////////////////////////////////////////////////////////////////////
  // TAP controller
  bsl_pkg::bsl_tap_type state_reg;
  bsl_pkg::bsl_tap_type state_next;

  always_comb begin
    case (state_reg)  // Standard sixteen-state walk
      bsl_pkg::TAP_RESET:
        state_next = tms_s ? bsl_pkg::TAP_RESET : bsl_pkg::TAP_IDLE;
      bsl_pkg::TAP_IDLE:
        state_next = tms_s ? bsl_pkg::TAP_SEL_DR : bsl_pkg::TAP_IDLE;
      bsl_pkg::TAP_SEL_DR:
        state_next = tms_s ? bsl_pkg::TAP_SEL_IR : bsl_pkg::TAP_CAP_DR;
      bsl_pkg::TAP_CAP_DR:
        state_next = tms_s ? bsl_pkg::TAP_EX1_DR : bsl_pkg::TAP_SH_DR;
      bsl_pkg::TAP_SH_DR:
        state_next = tms_s ? bsl_pkg::TAP_EX1_DR : bsl_pkg::TAP_SH_DR;
      bsl_pkg::TAP_EX1_DR:
        state_next = tms_s ? bsl_pkg::TAP_UPD_DR : bsl_pkg::TAP_PA_DR;
      bsl_pkg::TAP_PA_DR:
        state_next = tms_s ? bsl_pkg::TAP_EX2_DR : bsl_pkg::TAP_PA_DR;
      bsl_pkg::TAP_EX2_DR:
        state_next = tms_s ? bsl_pkg::TAP_UPD_DR : bsl_pkg::TAP_SH_DR;
      bsl_pkg::TAP_UPD_DR:
        state_next = tms_s ? bsl_pkg::TAP_SEL_DR : bsl_pkg::TAP_IDLE;
      bsl_pkg::TAP_SEL_IR:
        state_next = tms_s ? bsl_pkg::TAP_RESET : bsl_pkg::TAP_CAP_IR;
      bsl_pkg::TAP_CAP_IR:
        state_next = tms_s ? bsl_pkg::TAP_EX1_IR : bsl_pkg::TAP_SH_IR;
      bsl_pkg::TAP_SH_IR:
        state_next = tms_s ? bsl_pkg::TAP_EX1_IR : bsl_pkg::TAP_SH_IR;
      bsl_pkg::TAP_EX1_IR:
        state_next = tms_s ? bsl_pkg::TAP_UPD_IR : bsl_pkg::TAP_PA_IR;
      bsl_pkg::TAP_PA_IR:
        state_next = tms_s ? bsl_pkg::TAP_EX2_IR : bsl_pkg::TAP_PA_IR;
      bsl_pkg::TAP_EX2_IR:
        state_next = tms_s ? bsl_pkg::TAP_UPD_IR : bsl_pkg::TAP_SH_IR;
      bsl_pkg::TAP_UPD_IR:
        state_next = tms_s ? bsl_pkg::TAP_SEL_DR : bsl_pkg::TAP_IDLE;
      default:
        state_next = bsl_pkg::TAP_RESET;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg <= bsl_pkg::TAP_RESET;
    end else if (tck_rise) begin
      state_reg <= state_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Instruction register and decode
  logic [`BSL_IR_W-1:0] ir_shift_reg;
  logic [`BSL_IR_W-1:0] ir_reg;
  wire in_cap_ir = state_reg == bsl_pkg::TAP_CAP_IR;
  wire in_sh_ir = state_reg == bsl_pkg::TAP_SH_IR;
  wire in_cap_dr = state_reg == bsl_pkg::TAP_CAP_DR;
  wire in_sh_dr = state_reg == bsl_pkg::TAP_SH_DR;
  // Fixed capture doubles as the part's marker in the chain
  wire [`BSL_IR_W-1:0] ir_cap_val = {IR_CAPTURE[`BSL_IR_W-1:2],
    `BSL_IR_CAP_LOW};

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ir_shift_reg <= '0;
    end else if (tck_rise && in_cap_ir) begin
      ir_shift_reg <= ir_cap_val;
    end else if (tck_rise && in_sh_ir) begin
      ir_shift_reg <= {tdi_s, ir_shift_reg[`BSL_IR_W-1:1]};
    end
  end

  // Reset of the test logic falls back to bypass, system path free
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ir_reg <= `BSL_CODE_BYPASS;
    end else if (tck_fall && state_reg == bsl_pkg::TAP_RESET) begin
      ir_reg <= `BSL_CODE_BYPASS;
    end else if (tck_fall && state_reg == bsl_pkg::TAP_UPD_IR) begin
      ir_reg <= ir_shift_reg;
    end
  end

  wire is_extest = ir_reg == `BSL_CODE_EXTEST;
  wire is_sample = ir_reg == CODE_SAMPLE;
  wire is_clamp = ir_reg == `BSL_CODE_CLAMP;
  wire is_highz = ir_reg == `BSL_CODE_HIGHZ;
  // Everything else routes the bypass stage
  wire sel_chain = is_extest || is_sample;
  wire test_drive = is_extest || is_clamp;

  //////////////////////////////////////////////////////////////////////////
  // Bypass stage and boundary chain
  logic bypass_reg;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      bypass_reg <= 1'b0;
    end else if (tck_rise && in_cap_dr && !sel_chain) begin
      bypass_reg <= 1'b0;
    end else if (tck_rise && in_sh_dr && !sel_chain) begin
      bypass_reg <= tdi_s;
    end
  end

  logic [NC-1:0] cell_par;
  logic [NC-1:0] cell_so;
  logic [NC-1:0] cell_upd;
  wire a_en_sys = !a_pin1_s && !a_pin2_s;
  wire b_en_sys = !b_pin1_s && !b_pin2_s;
  wire cap_chain = tck_rise && in_cap_dr && sel_chain;
  wire sh_chain = tck_rise && in_sh_dr && sel_chain;
  // Update on the fall only under an instruction that owns the chain
  wire upd_chain = tck_fall && state_reg == bsl_pkg::TAP_UPD_DR
    && sel_chain;

  always_comb begin
    cell_par = '0;
    cell_par[`BSL_POS_A_PIN1] = a_pin1_s;
    cell_par[`BSL_POS_A_PIN2] = a_pin2_s;
    cell_par[`BSL_POS_A_INT] = a_en_sys;
    cell_par[`BSL_POS_B_PIN1] = b_pin1_s;
    cell_par[`BSL_POS_B_PIN2] = b_pin2_s;
    cell_par[`BSL_POS_B_INT] = b_en_sys;
    for (int i = 0; i < NB; i++) begin
      cell_par[`BSL_POS_A_IN0 - i] = a_in_s[i];
      cell_par[`BSL_POS_B_IN0 - i] = b_in_s[i];
      cell_par[`BSL_POS_A_OUT0 - i] = a_in_s[i];
      cell_par[`BSL_POS_B_OUT0 - i] = b_in_s[i];
    end
  end

  genvar k;
  generate
    for (k = 0; k < NC; k++) begin : g_cell
      // Controlling cells on outputs and internal enables
      localparam bit CTL = (k <= `BSL_POS_A_OUT0)
        || (k == `BSL_POS_A_INT) || (k == `BSL_POS_B_INT);
      bsl_scan_cell #(.CONTROL(CTL)) u_cell (
        .clk(clk),
        .resetn(resetn),
        .capture_en(cap_chain),
        .shift_en(sh_chain),
        .update_en(upd_chain),
        .par_in(cell_par[k]),
        .ser_in((k == NC - 1) ? tdi_s : cell_so[(k + 1) % NC]),
        .ser_out(cell_so[k]),
        .upd_out(cell_upd[k])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Serial out and system outputs
  logic [NB-1:0] a_upd;
  logic [NB-1:0] b_upd;

  always_comb begin
    for (int i = 0; i < NB; i++) begin
      a_upd[i] = cell_upd[`BSL_POS_A_OUT0 - i];
      b_upd[i] = cell_upd[`BSL_POS_B_OUT0 - i];
    end
  end

  wire tdo_next = in_sh_ir ? ir_shift_reg[0] :
    (sel_chain ? cell_so[0] : bypass_reg);
  // Internal enables gate only their own byte
  wire a_oe_next = !is_highz && (test_drive ? cell_upd[`BSL_POS_A_INT]
    : a_en_sys);
  wire b_oe_next = !is_highz && (test_drive ? cell_upd[`BSL_POS_B_INT]
    : b_en_sys);
  wire [NB-1:0] a_d_next = test_drive ? a_upd : a_in_s;
  wire [NB-1:0] b_d_next = test_drive ? b_upd : b_in_s;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      tdo <= 1'b0;
      tdo_en <= 1'b0;
    end else if (tck_fall) begin
      tdo <= tdo_next;
      tdo_en <= in_sh_ir || in_sh_dr;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      a_side_driven_out <= '0;
      b_side_driven_out <= '0;
      a_side_out_en <= 1'b0;
      b_side_out_en <= 1'b0;
    end else begin
      a_side_driven_out <= a_d_next;
      b_side_driven_out <= b_d_next;
      a_side_out_en <= a_oe_next;
      b_side_out_en <= b_oe_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_side_path_a: assert property (
    (!test_drive && !is_highz && a_en_sys) |=> (a_side_out_en
      && a_side_driven_out == $past(a_in_s)))
    else $error("A side not driven from its inputs");
  b_side_float_a: assert property (
    (!test_drive && (b_pin1_s || b_pin2_s)) |=> !b_side_out_en)
    else $error("B side driven while an enable pin is high");
  observe_capture_a: assert property (
    cap_chain |=> cell_so[`BSL_POS_A_IN0] == $past(a_in_s[0]))
    else $error("Input cell did not capture its pin");
  extest_enable_a: assert property (
    is_extest |=> (a_side_out_en == $past(cell_upd[`BSL_POS_A_INT])
      && b_side_out_en == $past(cell_upd[`BSL_POS_B_INT])))
    else $error("Internal enable cell not steering its byte");
  clamp_data_a: assert property (
    is_clamp |=> b_side_driven_out == $past(b_upd))
    else $error("Clamp does not drive from update cells");
  bypass_zero_a: assert property (
    (tck_rise && in_cap_dr && !sel_chain) |=> !bypass_reg)
    else $error("Bypass stage did not capture zero");
  ir_capture_a: assert property (
    (tck_rise && in_cap_ir) |=> ir_shift_reg[1:0] == `BSL_IR_CAP_LOW)
    else $error("Instruction capture low bits wrong");
  highz_float_a: assert property (
    is_highz |=> !a_side_out_en && !b_side_out_en)
    else $error("Outputs driven under high-z");
  tdo_fall_a: assert property (
    $changed(tdo) |-> $past(tck_fall))
    else $error("Serial out changed away from a falling edge");
  tap_reset_a: assert property (
    (tck_fall && state_reg == bsl_pkg::TAP_RESET)
      |=> ir_reg == `BSL_CODE_BYPASS)
    else $error("Test logic reset did not select bypass");

  cover_extest_c: cover property (is_extest && upd_chain);
  cover_clamp_c: cover property (is_clamp ##1 a_side_out_en);
  cover_ir_shift_c: cover property (tck_rise && in_sh_ir);
  cover_dr_shift_c: cover property (sh_chain);

endmodule // bsl_line_driver
`default_nettype wire

// [bsl_jtag_host.sv]
// Behavioural test controller on the four-wire test port.
// Assumes the testbench calls its tasks; tck stands still between them.
`timescale 1ns/1ps
`default_nettype none
module bsl_jtag_host (
  // Test port
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_en
);
  localparam int HALF = 200;
  // High only while every shift step saw the serial enable
  logic shift_en_ok;

  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    shift_en_ok = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Moves only while tck is low, so the device sees stable levels
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #HALF;
    o = tdo;
    tck = 1'b1;
    #HALF;
    tck = 1'b0;
  endtask

  task automatic reset_tap();
    logic o;
    for (int i = 0; i < 5; i++) step(1'b1, ~tdi, o);
    step(1'b0, ~tdi, o);
    tdi = ~tdi;
  endtask

  // Idle to Idle; the captured value comes back for identity checks
  task automatic scan_ir(input logic [7:0] v, output logic [7:0] cap);
    logic o;
    shift_en_ok = 1'b1;
    #7;
    step(1'b1, 1'b0, o);
    step(1'b1, 1'b1, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b1, o);
    for (int i = 0; i < 8; i++) begin
      step(logic'(i == 7), v[i], o);
      cap[i] = o;
      shift_en_ok = shift_en_ok & tdo_en;
    end
    // Pause-IR and Exit2-IR on the way to Update-IR
    step(1'b0, 1'b0, o);
    step(1'b1, 1'b0, o);
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b1, o);
    tdi = ~tdi;
  endtask

  // Bit i sent lands in cell i; cell 0 leaves first
  task automatic scan_dr(input int n, input logic [41:0] v,
      output logic [41:0] cap);
    logic o;
    cap = '0;
    shift_en_ok = 1'b1;
    #7;
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b1, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      step(logic'(i == n - 1), v[i], o);
      cap[i] = o;
      shift_en_ok = shift_en_ok & tdo_en;
    end
    // Pause-DR and Exit2-DR on the way to Update-DR
    step(1'b0, 1'b1, o);
    step(1'b1, 1'b1, o);
    step(1'b1, 1'b1, o);
    step(1'b0, 1'b0, o);
    tdi = ~tdi;
  endtask
endmodule // bsl_jtag_host
`default_nettype wire

// [tb_boundary_scan_line_driver.sv]
// Self-checking bench for the boundary-scan line driver.
// Assumes bsl_jtag_host plays the test controller.
`timescale 1ns/1ps
`default_nettype none
`include "bsl_consts.svh"
module tb_boundary_scan_line_driver;
  localparam logic [7:0] CAP_VAL = 8'h9d; // Arbitrary, low bits 01
  localparam logic [7:0] SAMPLE_OP = 8'h41; // Arbitrary code
  logic clk, resetn;
  logic [8:0] a_in, b_in;
  logic [3:0] oe_n;
  wire logic [8:0] a_out, b_out;
  wire logic a_en, b_en, tck, tms, tdi, tdo, tdo_en;
  int fail_count, tests_run;
  logic [7:0] ir_cap, op;
  logic [41:0] cap, pre, pre2;

  bsl_line_driver #(.IR_CAPTURE(CAP_VAL), .CODE_SAMPLE(SAMPLE_OP))
    i_bsl_line_driver (.clk(clk), .resetn(resetn), .a_side_data_in(a_in),
    .b_side_data_in(b_in), .a_enable_pin_first_n(oe_n[0]),
    .a_enable_pin_second_n(oe_n[1]), .b_enable_pin_first_n(oe_n[2]),
    .b_enable_pin_second_n(oe_n[3]), .a_side_driven_out(a_out),
    .a_side_out_en(a_en), .b_side_driven_out(b_out), .b_side_out_en(b_en),
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_en(tdo_en));

  bsl_jtag_host i_bsl_jtag_host (.tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_en(tdo_en));

  always #25 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [41:0] exp,
      input logic [41:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_out(input string what, input logic ae,
      input logic be, input logic [8:0] ad, input logic [8:0] bd);
    check({what, " enables"}, 42'({ae, be}), 42'({a_en, b_en}));
    check({what, " serial enable"}, 42'h0, 42'(tdo_en));
    if (ae)
      check({what, " a data"}, 42'(ad), 42'(a_out));
    if (be)
      check({what, " b data"}, 42'(bd), 42'(b_out));
  endtask

  task automatic check_normal(input string what);
    check_out(what, ~(oe_n[0] | oe_n[1]), ~(oe_n[2] | oe_n[3]), a_in, b_in);
  endtask

  // Pins cross two synchronisers and an output register
  task automatic settle();
    repeat (4) @(negedge clk);
  endtask

  function automatic logic [8:0] rev9(input logic [8:0] v);
    for (int i = 0; i < 9; i++) rev9[i] = v[8 - i];
  endfunction

  task automatic load_ir(input logic [7:0] code);
    i_bsl_jtag_host.scan_ir(code, ir_cap);
    check("ir capture", 42'({CAP_VAL[7:2], 2'h1}), 42'(ir_cap));
    check("ir shift enable", 42'h1,
      42'(i_bsl_jtag_host.shift_en_ok));
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    #2000000;
    fail_count++;
    complete_run();
  end

  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    a_in = 9'h0;
    b_in = 9'h0;
    oe_n = 4'h0;
    fail_count = 0;
    tests_run = 0;
    pre = {6'h08, 18'h2b4c1, 9'h15a, 9'h0e7};
    pre2 = {6'h01, 18'h0, 9'h0a3, 9'h1c4};
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    // Every enable pin combination, data moving each time
    for (int k = 0; k < 16; k++) begin
      oe_n = 4'(k);
      a_in = 9'(k * 37 + 5);
      b_in = ~a_in;
      settle();
      check_normal("normal");
    end
    i_bsl_jtag_host.reset_tap();
    @(negedge clk);
    oe_n = 4'h2;
    a_in = 9'h1a5;
    b_in = 9'h0c3;
    load_ir(SAMPLE_OP);
    i_bsl_jtag_host.scan_dr(42, pre, cap);
    check("sample chain", {6'h11, rev9(a_in), rev9(b_in), rev9(a_in),
      rev9(b_in)}, cap);
    check("dr shift enable", 42'h1,
      42'(i_bsl_jtag_host.shift_en_ok));
    check_normal("sample");
    load_ir(`BSL_CODE_EXTEST);
    settle();
    check_out("extest", 1'b1, 1'b0, rev9(pre[17:9]),
      rev9(pre[8:0]));
    @(negedge clk);
    a_in = 9'h05e;
    oe_n = 4'hf;
    settle();
    check_out("extest pins", 1'b1, 1'b0, rev9(pre[17:9]),
      rev9(pre[8:0]));
    i_bsl_jtag_host.scan_dr(42, pre2, cap);
    check("extest inputs", 42'({rev9(a_in), rev9(b_in)}),
      42'(cap[35:18]));
    check_out("extest b", 1'b0, 1'b1, rev9(pre2[17:9]),
      rev9(pre2[8:0]));
    @(negedge clk);
    oe_n = 4'h0;
    // Bypass routes: zero captured, then the first bit sent
    for (int k = 0; k < 4; k++) begin
      op = k == 0 ? `BSL_CODE_CLAMP : k == 1 ? `BSL_CODE_HIGHZ :
        k == 2 ? 8'h5a : `BSL_CODE_BYPASS;
      load_ir(op);
      i_bsl_jtag_host.scan_dr(2, 42'h3, cap);
      check("bypass", 42'h2, 42'(cap[1:0]));
      settle();
      if (k == 0)
        check_out("clamp", 1'b0, 1'b1, 9'h0,
          rev9(pre2[8:0]));
      else if (k == 1)
        check_out("high-z", 1'b0, 1'b0, 9'h0, 9'h0);
      else
        check_normal("unlisted");
    end
    load_ir(`BSL_CODE_EXTEST);
    i_bsl_jtag_host.reset_tap();
    settle();
    check_normal("tap reset");
    complete_run();
  end
endmodule // tb_boundary_scan_line_driver
`default_nettype wire
